// ---- rtl/pms_params.svh ----
// Purpose: Constants for the management-bus status readback block
// Assumes: Included by the package users in rtl/
// Notes: Command codes, bit positions, reset values and counts
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define PMS_CMD_FAN_SPEED 8'h90
`define PMS_CMD_MAKER 8'h99
`define PMS_CMD_MODEL 8'h9a
`define PMS_CMD_REVISION 8'h9b
`define PMS_CMD_SERIAL 8'h9e
`define PMS_CMD_SUMMARY 8'hd0
`define PMS_CMD_UNIT 8'hd1
`define PMS_CMD_ALARM 8'hd2

// ----------------------------------------------------------------
// Response lengths in data bytes (byte count excludes the check byte)
// ----------------------------------------------------------------
`define PMS_LEN_FAN 8'h02
`define PMS_LEN_MAKER 8'h06
`define PMS_LEN_MODEL 8'h10
`define PMS_LEN_REVISION 8'h08
`define PMS_LEN_SERIAL 8'h10
`define PMS_LEN_SUMMARY 8'h0b
`define PMS_LEN_UNIT 8'h02
`define PMS_LEN_ALARM 8'h03

// ----------------------------------------------------------------
// Status and alarm bit positions, reset values
// ----------------------------------------------------------------
`define PMS_S2_PEC_ERR 7
`define PMS_S2_OC_HICCUP 6
`define PMS_S2_BAD_CMD 5
`define PMS_S2_CAPACITY 4
`define PMS_S2_ISO_FAIL 3
`define PMS_S2_RANGE_ERR 1
`define PMS_S2_REMOTE 0
`define PMS_S1_OT_HICCUP 7
`define PMS_S1_ISO_OK 6
`define PMS_S1_INT_FAULT 5
`define PMS_S1_SHUTDOWN 4
`define PMS_S1_EXT_FAULT 2
`define PMS_S1_IND_TEST 1
`define PMS_S1_OUT_ON 0
`define PMS_S2_RESET 8'h40
`define PMS_S1_RESET 8'h80
`define PMS_A3_RESET 8'h00
`define PMS_A2_POWER_DELIV 0

// Shared current threshold in amperes and code per ampere of the share reading
`define PMS_SHARE_LIMIT_A 10
`define PMS_SHARE_LSB_PER_A 16
`define PMS_SHARE_LIMIT_CODE 16'h00a0

// CRC-8 polynomial x^8+x^2+x+1 and filler byte for stale data
`define PMS_CRC_POLY 8'h07
`define PMS_FILL_BYTE 8'hff

`endif

// ---- rtl/pms_pkg.sv ----
// Purpose: Types for the management-bus status readback block
// Assumes: Nothing
// Notes: Constants live in pms_params.svh
package pms_pkg;
  // Link side transaction phase
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_CMD, LK_RDBYTE, LK_WRBYTE, LK_IGNORE
  } pms_link_type;
endpackage

// ---- rtl/pms_crc8.sv ----
// Purpose: One-byte step of the bus check-byte CRC-8
// Assumes: Pure combinational, used in the link domain
// Notes: Polynomial 0x07, initial value zero, MSB first
`timescale 1ns/10ps
`default_nettype none
`include "pms_params.svh"

module pms_crc8 (
  input wire logic [7:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [7:0] crcOut
);

  // ----------------------------------------------------------------
  // Bitwise step, unrolled by a loop over the eight data bits
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    c = crcIn ^ dataIn;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `PMS_CRC_POLY) : (c << 1);
    end
    crcOut = c;
  end

endmodule
`default_nettype wire

// ---- rtl/pms_status_readback.sv ----
// Purpose: Target-side command handler for fan, identity and status reads
// Assumes: Host drives the bus clock; bus data pin is open drain
// Notes: Link logic runs on busClk, status logic on sys_clk
//
// Operation
// (R1) Fan speed read returns direct-format RPM
// (R2) Each identity code read as its own transaction
// (R3) Maker name: ASCII, at most six characters
// (R4) Model number: sixteen ASCII characters
// (R5) Revision read returns eight bytes
// (R6) Serial: sixteen characters, year site week number
// (R7) Over two bytes uses block read
// (R8) Block read starts with data byte count
// (R9) Multi-byte values sent low byte first
// (R10) Host ends read with not-acknowledge, stop
// (R11) Host writes command, repeated start, reads
// (R12) Summary: count eleven, flags, volts, amps, temp
// (R13) Summary temperature nearest its shutdown threshold
// (R14) Unit status returns Status-2 then Status-1
// (R15) Status-2 bit layout, overcurrent mode resets one
// (R16) Status-1 bit layout, overtemperature mode resets one
// (R17) Only destructive isolation fault forces shutdown
// (R18) Alarm read returns Alarm-3 down to Alarm-1
// (R19) Alarm-3 bit layout, all reset zero
// (R20) Flags readable by summary or in groups
// (R21) Data not ready returns all-ones bytes; block reads still send the real count byte first
// (R22) Power delivery alarm above ten amperes share
// (R23) Check byte CRC-8; write mismatch flags error
// (R24) Unknown command flags invalid, returns nothing
`timescale 1ns/10ps
`default_nettype none
`include "pms_params.svh"

module pms_status_readback (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic busClk,
  input wire logic busSclIn,
  input wire logic busDataIn,
  output logic busDataOut,
  output logic busDataOe,
  input wire logic [6:0] targetAddr,
  input wire logic [15:0] fanRpm,
  input wire logic [15:0] outVoltage,
  input wire logic [15:0] outCurrent,
  input wire logic [15:0] tempPrimary,
  input wire logic [15:0] tempPrimaryLimit,
  input wire logic [15:0] tempConverter,
  input wire logic [15:0] tempConverterLimit,
  input wire logic [15:0] shareCurrent,
  input wire logic [7:0] status2Live,
  input wire logic [7:0] status1Live,
  input wire logic [7:0] alarm3Live,
  input wire logic [7:0] alarm2Live,
  input wire logic [7:0] alarm1Live,
  input wire logic isoFault,
  input wire logic isoDestructive,
  input wire logic dataReady,
  input wire logic [127:0] makerNameString,
  input wire logic [127:0] modelString,
  input wire logic [63:0] revisionString,
  input wire logic [127:0] serialString,
  output logic internalShutdown,
  output logic [7:0] unitStatusHigh,
  output logic [7:0] unitStatusLow,
  output logic [7:0] alarmGroupThree
);

  // ----------------------------------------------------------------
  // System domain: status flag registers
  // ----------------------------------------------------------------
  logic [7:0] status2_q;
  logic [7:0] status1_q;
  logic [7:0] alarm3_q;
  logic [7:0] alarm2_q;
  logic shutdown_q;
  logic [15:0] temp_q;
  logic [2:0] pecTogSync_q;
  logic [2:0] cmdTogSync_q;
  logic pecEvent;
  logic cmdEvent;
  logic shareOver;
  logic [15:0] marginPrimary;
  logic [15:0] marginConverter;
  logic [7:0] cmd_q;
  logic snapReq_q;
  logic pecTog_q;
  logic cmdTog_q;

  // Events from the link arrive as toggles; third stage is the edge reference
  assign pecEvent = pecTogSync_q[2] ^ pecTogSync_q[1];
  assign cmdEvent = cmdTogSync_q[2] ^ cmdTogSync_q[1];
  assign shareOver = shareCurrent > `PMS_SHARE_LIMIT_CODE; // R22
  // Headroom to each shutdown threshold; smallest headroom wins
  assign marginPrimary = tempPrimaryLimit - tempPrimary;
  assign marginConverter = tempConverterLimit - tempConverter;

  // Toggle synchronisers for the link events
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pecTogSync_q <= 3'h0;
      cmdTogSync_q <= 3'h0;
    end else begin
      pecTogSync_q <= {pecTogSync_q[1:0], pecTog_q};
      cmdTogSync_q <= {cmdTogSync_q[1:0], cmdTog_q};
    end
  end

  // Status-2: sticky error bits hold, live bits follow the plant
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status2_q <= `PMS_S2_RESET; // R15
    end else begin
      status2_q[`PMS_S2_OC_HICCUP] <= status2Live[`PMS_S2_OC_HICCUP]; // R15
      status2_q[`PMS_S2_CAPACITY] <= status2Live[`PMS_S2_CAPACITY];
      status2_q[`PMS_S2_ISO_FAIL] <= isoFault;
      status2_q[`PMS_S2_RANGE_ERR] <= status2Live[`PMS_S2_RANGE_ERR];
      status2_q[`PMS_S2_REMOTE] <= status2Live[`PMS_S2_REMOTE];
      status2_q[2] <= 1'b0;
      // Sticky until reset; there is no clear path, so no set/clear race
      status2_q[`PMS_S2_PEC_ERR] <= status2_q[`PMS_S2_PEC_ERR] | pecEvent; // R23
      status2_q[`PMS_S2_BAD_CMD] <= status2_q[`PMS_S2_BAD_CMD] | cmdEvent; // R24
    end
  end

  // Status-1 and the isolation shutdown
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status1_q <= `PMS_S1_RESET; // R16
      shutdown_q <= 1'b0;
    end else begin
      status1_q <= {status1Live[7], ~isoFault & status1Live[6], status1Live[5],
                    status1Live[4] | shutdown_q, 1'b0, status1Live[2:0]}; // R16
      // Non-destructive isolation fault leaves the output running
      shutdown_q <= shutdown_q | (isoFault & isoDestructive); // R17
    end
  end

  // Alarm-3 and Alarm-2 capture, worst-case temperature select
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm3_q <= `PMS_A3_RESET; // R19
      alarm2_q <= 8'h00;
      temp_q <= 16'h0000;
    end else begin
      alarm3_q <= {alarm3Live[7:3], 2'b00, alarm3Live[0] | isoFault}; // R19
      alarm2_q <= {alarm2Live[7:1], alarm2Live[0] | shareOver}; // R22
      temp_q <= (marginPrimary <= marginConverter) ? tempPrimary : tempConverter; // R13
    end
  end

  // Top outputs come straight from flip-flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      unitStatusHigh <= `PMS_S2_RESET;
      unitStatusLow <= `PMS_S1_RESET;
      alarmGroupThree <= `PMS_A3_RESET;
      internalShutdown <= 1'b0;
    end else begin
      unitStatusHigh <= status2_q;
      unitStatusLow <= status1_q;
      alarmGroupThree <= alarm3_q;
      internalShutdown <= shutdown_q; // R17
    end
  end

  // ----------------------------------------------------------------
  // Snapshot handshake: the link requests, system domain captures
  // ----------------------------------------------------------------
  logic [255:0] snap_q;
  logic snapAck_q;
  logic [1:0] reqSync_q;
  logic snapReady;

  // Response image per command: byte 0 is the first byte sent after the count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reqSync_q <= 2'h0;
      snapAck_q <= 1'b0;
      snap_q <= '0;
    end else begin
      reqSync_q <= {reqSync_q[0], snapReq_q};
      if (reqSync_q[1] != snapAck_q) begin
        snapAck_q <= reqSync_q[1];
        snap_q <= '0;
        unique case (cmd_q)
          `PMS_CMD_FAN_SPEED: snap_q[15:0] <= fanRpm; // R1 R9
          `PMS_CMD_MAKER: snap_q[127:0] <= makerNameString; // R3
          `PMS_CMD_MODEL: snap_q[127:0] <= modelString; // R4
          `PMS_CMD_REVISION: snap_q[63:0] <= revisionString; // R5
          `PMS_CMD_SERIAL: snap_q[127:0] <= serialString; // R6
          `PMS_CMD_SUMMARY: snap_q[87:0] <= {temp_q, outCurrent, outVoltage, alarm1Live,
                                            alarm2_q, alarm3_q, status1_q, status2_q}; // R12 R20
          `PMS_CMD_UNIT: snap_q[15:0] <= {status1_q, status2_q}; // R14
          `PMS_CMD_ALARM: snap_q[23:0] <= {alarm1Live, alarm2_q, alarm3_q}; // R18
          default: snap_q <= '0;
        endcase
        // Data not yet valid: answer with filler instead of wrong values
        if (!dataReady) snap_q <= {32{`PMS_FILL_BYTE}}; // R21
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: bus engine on the host's clock
  // ----------------------------------------------------------------
  logic [1:0] dinSync_q;
  logic [1:0] clSync_q;
  logic sdaPrev_q;
  logic clPrev_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic [7:0] crc_q;
  logic [7:0] byteIdx_q;
  logic [7:0] len;
  logic [1:0] rstSync_q;
  logic isBlock;
  logic known;
  logic [7:0] txByte;
  logic [7:0] crcNext;
  logic [7:0] crcByte;
  pms_pkg::pms_link_type state_q;

  // Level of the data pin at the sampling edge
  wire sda = dinSync_q[1];
  wire risingClk = clSync_q[1] & ~clPrev_q;
  wire fallingClk = ~clSync_q[1] & clPrev_q;
  wire startCond = ~sda & sdaPrev_q & clSync_q[1];
  wire stopCond = sda & ~sdaPrev_q & clSync_q[1];
  wire linkRst = rstSync_q[1];
  wire addrMatch = shift_q[7:1] == targetAddr;
  // Bytes that we acknowledge: matching address, command, written check byte
  wire ackOwn = (state_q == pms_pkg::LK_ADDR) ? addrMatch :
                (state_q == pms_pkg::LK_CMD || state_q == pms_pkg::LK_WRBYTE);

  // Length and decode: block read for anything over two bytes
  function automatic logic [7:0] respLen(input logic [7:0] c);
    unique case (c)
      `PMS_CMD_FAN_SPEED: respLen = `PMS_LEN_FAN;
      `PMS_CMD_MAKER: respLen = `PMS_LEN_MAKER;
      `PMS_CMD_MODEL: respLen = `PMS_LEN_MODEL;
      `PMS_CMD_REVISION: respLen = `PMS_LEN_REVISION;
      `PMS_CMD_SERIAL: respLen = `PMS_LEN_SERIAL;
      `PMS_CMD_SUMMARY: respLen = `PMS_LEN_SUMMARY;
      `PMS_CMD_UNIT: respLen = `PMS_LEN_UNIT;
      `PMS_CMD_ALARM: respLen = `PMS_LEN_ALARM;
      default: respLen = 8'h00;
    endcase
  endfunction

  assign len = respLen(cmd_q);
  assign known = len != 8'h00;
  assign isBlock = len > 8'h02; // R7
  // Byte order: optional count, data low byte first, then the check byte
  assign crcByte = isBlock ? (byteIdx_q - 8'h01) : byteIdx_q;
  assign txByte = (isBlock && byteIdx_q == 8'h00) ? len : // R8
                  (crcByte == len) ? crc_q : // R23
                  snap_q[{crcByte[4:0], 3'b000} +: 8]; // R9

  pms_crc8 u_crc (
    .crcIn(crc_q),
    .dataIn(state_q == pms_pkg::LK_RDBYTE ? txByte : shift_q),
    .crcOut(crcNext)
  );

  // Reset and both bus pins pass two flip-flops on busClk before any use
  always_ff @(posedge busClk) begin
    rstSync_q <= {rstSync_q[0], srst};
    dinSync_q <= {dinSync_q[0], busDataIn};
    clSync_q <= {clSync_q[0], busSclIn};
    sdaPrev_q <= sda;
    clPrev_q <= clSync_q[1];
  end

  // Transaction engine: write address, command, repeated start, read
  // A byte is acted on at its acknowledge slot, when shift_q holds all of it
  always_ff @(posedge busClk) begin
    if (linkRst) begin
      state_q <= pms_pkg::LK_IDLE;
      busDataOe <= 1'b0;
      busDataOut <= 1'b0;
      bitCnt_q <= 4'h0;
      crc_q <= 8'h00;
      snapReq_q <= 1'b0;
      pecTog_q <= 1'b0;
      cmdTog_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= pms_pkg::LK_IDLE;
      busDataOe <= 1'b0;
      crc_q <= 8'h00;
    end else if (startCond) begin
      // Repeated start keeps the running check byte
      state_q <= pms_pkg::LK_ADDR; // R11
      bitCnt_q <= 4'h0;
      busDataOe <= 1'b0;
    end else if (risingClk && bitCnt_q != 4'h8) begin
      shift_q <= {shift_q[6:0], sda};
      bitCnt_q <= bitCnt_q + 4'h1;
    end else if (risingClk) begin
      bitCnt_q <= 4'h0;
      unique case (state_q)
        pms_pkg::LK_ADDR: begin
          crc_q <= crcNext;
          byteIdx_q <= 8'h00;
          if (!addrMatch) state_q <= pms_pkg::LK_IGNORE;
          else if (!shift_q[0]) state_q <= pms_pkg::LK_CMD;
          else begin
            state_q <= pms_pkg::LK_RDBYTE;
            snapReq_q <= ~snapReq_q;
          end
        end
        pms_pkg::LK_CMD: begin
          crc_q <= crcNext;
          cmd_q <= shift_q;
          state_q <= pms_pkg::LK_WRBYTE;
          // One command per transaction, no multi-code transfers
          if (respLen(shift_q) == 8'h00) cmdTog_q <= ~cmdTog_q; // R2 R24
        end
        pms_pkg::LK_WRBYTE: begin
          // Extra written byte is a check byte; mismatch flags an error
          if (shift_q != crc_q) pecTog_q <= ~pecTog_q; // R23
        end
        pms_pkg::LK_RDBYTE: begin
          crc_q <= crcNext; // R23
          byteIdx_q <= byteIdx_q + 8'h01;
          // Host not-acknowledge on the check byte ends the read
          if (sda) state_q <= pms_pkg::LK_IGNORE; // R10
        end
        default: begin
        end
      endcase
    end else if (fallingClk) begin
      // Next slot: our acknowledge, or a read bit MSB first
      if (bitCnt_q == 4'h8) begin
        busDataOe <= ackOwn;
      end else begin
        busDataOe <= state_q == pms_pkg::LK_RDBYTE && known && !txByte[3'h7 - bitCnt_q[2:0]]; // R24
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  shutdown_iso_a: assert property (@(posedge sys_clk) disable iff (srst)
    isoFault && isoDestructive |-> ##2 internalShutdown) else $error("shutdown missing"); // R17
  no_shutdown_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(internalShutdown) |-> $past(shutdown_q)) else $error("shutdown cause"); // R17
  bad_cmd_a: assert property (@(posedge sys_clk) disable iff (srst)
    cmdEvent |=> status2_q[`PMS_S2_BAD_CMD]) else $error("invalid flag"); // R24
  pec_err_a: assert property (@(posedge sys_clk) disable iff (srst)
    pecEvent |=> status2_q[`PMS_S2_PEC_ERR]) else $error("pec flag"); // R23
  share_alarm_a: assert property (@(posedge sys_clk) disable iff (srst)
    shareOver |=> alarm2_q[`PMS_A2_POWER_DELIV]) else $error("share alarm"); // R22
  alarm3_gap_a: assert property (@(posedge sys_clk) disable iff (srst)
    alarm3_q[2:1] == 2'b00) else $error("alarm3 spare bits"); // R19
  status_out_a: assert property (@(posedge sys_clk) disable iff (srst)
    ##1 unitStatusHigh == $past(status2_q)) else $error("status copy"); // R15
  temp_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    marginPrimary < marginConverter |=> temp_q == $past(tempPrimary)) else $error("temp"); // R13
  iso_ok_a: assert property (@(posedge sys_clk) disable iff (srst)
    isoFault |=> !status1_q[`PMS_S1_ISO_OK]) else $error("iso ok"); // R16
  cover_shut_c: cover property (@(posedge sys_clk) $rose(internalShutdown));
  cover_cmd_c: cover property (@(posedge sys_clk) cmdEvent);
  cover_snap_c: cover property (@(posedge sys_clk) reqSync_q[1] != snapAck_q);

endmodule
`default_nettype wire

// ---- test/pms_host_model.sv ----
// Purpose: Bus host model that reads from the status readback target
// Assumes: One bit slot spans seven busClk cycles; the line has a pull-up
// Notes: Host drives the line low or releases it high; the target pulls it low
`timescale 1ns/10ps
`default_nettype none

module pms_host_model (
  input wire logic busClk,
  input wire logic busLine,
  output logic hostDrive,
  output logic hostScl
);
  // ----
  // Bit level
  // ----
  initial begin
    hostDrive = 1'b1;
    hostScl = 1'b1;
  end

  // Clock low, data set, clock high a full sync delay later, then sample
  task automatic slot(input logic b, output logic s);
    @(posedge busClk);
    #1 hostScl = 1'b0;
    @(posedge busClk);
    #1 hostDrive = b;
    repeat (3) @(posedge busClk);
    #1 hostScl = 1'b1;
    repeat (2) @(posedge busClk);
    #1 s = busLine;
  endtask

  // Data edge while the clock is high: falling is a start, rising a stop
  task automatic frame(input logic b0, input logic b1);
    logic s;
    slot(b0, s);
    @(posedge busClk);
    #1 hostDrive = b1;
    repeat (2) @(posedge busClk);
  endtask

  // Bytes go out high bit first; the ninth slot is released for the target
  task automatic sendByte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(b[i], s);
    end
    slot(1'b1, s);
  endtask

  // Acknowledge low on every byte but the last, which gets a high
  task automatic recvByte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      b[i] = s;
    end
    slot(last, s);
  endtask

  // ----
  // Transactions
  // ----
  // One command per transaction, never several combined
  task automatic readCmd(input logic [6:0] addr, input logic [7:0] cmd, input int n,
    output logic [7:0] rx [0:31]);
    frame(1'b1, 1'b0);
    sendByte({addr, 1'b0});
    sendByte(cmd);
    frame(1'b1, 1'b0);
    sendByte({addr, 1'b1});
    // Clock held high while the target fetches its snapshot
    repeat (10) @(posedge busClk);
    for (int i = 0; i < n; i++) begin
      recvByte(i == n - 1, rx[i]);
    end
    frame(1'b0, 1'b1);
  endtask

  // Command with no read phase, used for refused codes
  task automatic writeCmd(input logic [6:0] addr, input logic [7:0] cmd);
    frame(1'b1, 1'b0);
    sendByte({addr, 1'b0});
    sendByte(cmd);
    frame(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ---- test/pms_status_readback_tb_top.sv ----
// Purpose: Self-checking bench for the status readback target
// Assumes: Host model on the far side; random inputs from a fixed seed
// Notes: Expected bytes include a check byte worked out here
`timescale 1ns/10ps
`default_nettype none
`include "pms_params.svh"

module pms_status_readback_tb_top;
  typedef logic [7:0] pms_bq_type[$];
  localparam int CYCLE_LIMIT = 40000; // Whole run is near eighteen thousand cycles
  logic sys_clk = 1'b0;
  logic busClk = 1'b0;
  logic srst, dataReady, isoFault, isoDestructive, hostDrive, hostScl;
  logic [6:0] targetAddr;
  logic [15:0] fanRpm, outVoltage, outCurrent, shareCurrent;
  logic [15:0] tempPrimary, tempPrimaryLimit, tempConverter, tempConverterLimit;
  logic [7:0] status2Live, status1Live, alarm3Live, alarm2Live, alarm1Live, stickyHigh;
  logic [127:0] makerNameString, modelString, serialString;
  logic [63:0] revisionString;
  logic busDataOut, busDataOe, internalShutdown;
  logic [7:0] unitStatusHigh, unitStatusLow, alarmGroupThree;
  logic [7:0] got [0:31];
  wire logic busLine;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] cmdList [0:7] = '{8'h90, 8'h99, 8'h9a, 8'h9b, 8'h9e, 8'hd0, 8'hd1, 8'hd2};

  // Open drain line: pulled up, low while the target enables its driver
  assign busLine = hostDrive & ~busDataOe;

  always #2.5 sys_clk = ~sys_clk;
  always #3 busClk = ~busClk;

  pms_status_readback pms_status_readback_inst (.sys_clk(sys_clk), .srst(srst),
    .busClk(busClk), .busSclIn(hostScl), .busDataIn(busLine), .busDataOut(busDataOut),
    .busDataOe(busDataOe), .targetAddr(targetAddr), .fanRpm(fanRpm),
    .outVoltage(outVoltage), .outCurrent(outCurrent), .tempPrimary(tempPrimary),
    .tempPrimaryLimit(tempPrimaryLimit), .tempConverter(tempConverter),
    .tempConverterLimit(tempConverterLimit), .shareCurrent(shareCurrent),
    .status2Live(status2Live), .status1Live(status1Live), .alarm3Live(alarm3Live),
    .alarm2Live(alarm2Live), .alarm1Live(alarm1Live), .isoFault(isoFault),
    .isoDestructive(isoDestructive), .dataReady(dataReady),
    .makerNameString(makerNameString), .modelString(modelString),
    .revisionString(revisionString), .serialString(serialString),
    .internalShutdown(internalShutdown), .unitStatusHigh(unitStatusHigh),
    .unitStatusLow(unitStatusLow), .alarmGroupThree(alarmGroupThree));

  pms_host_model pms_host_model_inst (.busClk(busClk), .busLine(busLine),
    .hostDrive(hostDrive), .hostScl(hostScl));

  // ----
  // Expected values
  // ----
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `PMS_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Flag bytes per the bit layouts: spare bits zero, sticky bits from stickyHigh
  function automatic logic [7:0] expS2();
    return (status2Live & 8'h53) | {4'h0, isoFault, 3'h0} | stickyHigh;
  endfunction
  function automatic logic [7:0] expS1();
    return status1Live & 8'hf7 & ~{1'b0, isoFault, 6'h00};
  endfunction
  function automatic logic [7:0] expA3();
    return (alarm3Live & 8'hf9) | {7'h00, isoFault};
  endfunction

  // Full response of one command, check byte last
  function automatic pms_bq_type expectResp(input logic [7:0] cmd);
    pms_bq_type q;
    logic [127:0] src;
    logic [7:0] n, c;
    logic [15:0] t;
    src = '0;
    n = 8'h00;
    // Temperature with the least headroom to its limit
    t = ((tempPrimaryLimit - tempPrimary) <= (tempConverterLimit - tempConverter)) ?
      tempPrimary : tempConverter;
    case (cmd)
      8'h90: q = '{fanRpm[7:0], fanRpm[15:8]};
      8'h99: begin src = makerNameString; n = `PMS_LEN_MAKER; end
      8'h9a: begin src = modelString; n = `PMS_LEN_MODEL; end
      8'h9b: begin src = {64'h0, revisionString}; n = `PMS_LEN_REVISION; end
      8'h9e: begin src = serialString; n = `PMS_LEN_SERIAL; end
      8'hd0: q = '{`PMS_LEN_SUMMARY, expS2(), expS1(), expA3(),
        alarm2Live | {7'h00, shareCurrent > `PMS_SHARE_LIMIT_CODE}, alarm1Live,
        outVoltage[7:0], outVoltage[15:8], outCurrent[7:0], outCurrent[15:8], t[7:0], t[15:8]};
      8'hd1: q = '{expS2(), expS1()};
      default: q = '{`PMS_LEN_ALARM, expA3(),
        alarm2Live | {7'h00, shareCurrent > `PMS_SHARE_LIMIT_CODE}, alarm1Live};
    endcase
    // Block reads lead with the count of data bytes
    if (n != 8'h00) begin
      q.push_back(n);
      for (int i = 0; i < n; i++) begin
        q.push_back(src[8 * i +: 8]);
      end
    end
    if (!dataReady) begin
      foreach (q[i]) q[i] = `PMS_FILL_BYTE;
    end
    c = crcStep(crcStep(crcStep(8'h00, {targetAddr, 1'b0}), cmd), {targetAddr, 1'b1});
    foreach (q[i]) c = crcStep(c, q[i]);
    q.push_back(c);
    return q;
  endfunction

  // ----
  // Checking and stimulus
  // ----
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read one command and compare every byte, check byte included
  task automatic runRead(input logic [7:0] cmd);
    pms_bq_type q;
    q = expectResp(cmd);
    pms_host_model_inst.readCmd(targetAddr, cmd, q.size(), got);
    foreach (q[i]) cmp8($sformatf("byte %0d of cmd %h", i, cmd), q[i], got[i]);
    $display("test read %h done", cmd);
  endtask

  task automatic shuffleInputs();
    @(posedge sys_clk);
    #1;
    {fanRpm, outVoltage, outCurrent, tempPrimary, tempConverter} = {$urandom, $urandom, $urandom};
    tempPrimaryLimit = tempPrimary + 16'($urandom_range(1, 999));
    tempConverterLimit = tempConverter + 16'($urandom_range(1, 999));
    shareCurrent = 16'($urandom_range(16'h0090, 16'h00b0));
    {status2Live, status1Live, alarm3Live, alarm2Live, alarm1Live} = {$urandom, 8'($urandom)};
    {makerNameString, modelString} = {$urandom, $urandom, $urandom, $urandom, $urandom,
      $urandom, $urandom, $urandom};
    {serialString, revisionString} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(46832));
    {srst, dataReady, isoFault, isoDestructive, stickyHigh} = {3'b110, 1'b0, 8'h00};
    targetAddr = {1'b1, 6'($urandom)};
    shuffleInputs();
    repeat (4) @(posedge sys_clk);
    #1 srst = 1'b0;
    cmp8("status high reset", `PMS_S2_RESET, unitStatusHigh);
    cmp8("status low reset", `PMS_S1_RESET, unitStatusLow);
    cmp8("alarm three reset", `PMS_A3_RESET, alarmGroupThree);
    for (int r = 0; r < 2; r++) begin
      foreach (cmdList[k]) begin
        shuffleInputs();
        repeat (4) @(posedge sys_clk);
        cmp8("status high", expS2(), unitStatusHigh);
        cmp8("status low", expS1(), unitStatusLow);
        cmp8("alarm three", expA3(), alarmGroupThree);
        runRead(cmdList[k]);
      end
    end
    #1 dataReady = 1'b0;
    runRead(8'h90);
    #1 dataReady = 1'b1;
    // Refused code: flag rises within a bounded wait after the command
    pms_host_model_inst.writeCmd(targetAddr, 8'h55);
    for (int w = 0; w < 300 && unitStatusHigh[`PMS_S2_BAD_CMD] !== 1'b1; w++) begin
      @(posedge sys_clk);
    end
    stickyHigh = 8'h20;
    cmp8("invalid flag", 8'h01, {7'h00, unitStatusHigh[`PMS_S2_BAD_CMD]});
    runRead(8'hd1);
    #1 isoFault = 1'b1;
    repeat (10) @(posedge sys_clk);
    cmp8("shutdown mild", 8'h00, {7'h00, internalShutdown});
    #1 isoDestructive = 1'b1;
    repeat (10) @(posedge sys_clk);
    cmp8("shutdown hard", 8'h01, {7'h00, internalShutdown});
    $display("test isolation done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
